//--- bench/dma_arb_checker_properties.sv
// Port checker for the DMA channel arbiter.
// Assumes the single clock and the zero-wait register slave.
`timescale 1ns/1ps
`default_nettype none
module dma_arb_checker (
	// Clock and reset.
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	// Watched ports.
	input wire logic       i_bus_gnt,
	input wire logic       o_hreadyout,
	input wire logic       o_hresp,
	input wire logic       o_cyc_read,
	input wire logic       o_cyc_write,
	input wire logic [1:0] o_cyc_chan,
	input wire logic       o_unit_done,
	input wire logic [3:0] o_transfer_end_n
);
	// ==========================================================
	// Properties.
	// One domain, so one default clock and reset serve all.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	chk_read_write: assert property (o_cyc_read |=> o_unit_done)
		else $error("read cycle not followed by unit end");
	chk_no_overlap: assert property (!(o_cyc_read && o_cyc_write))
		else $error("read and write cycles overlap");
	chk_done_in_write: assert property (o_unit_done |-> $past(o_cyc_read))
		else $error("unit done without a read cycle before it");
	chk_release_gap: assert property ((o_unit_done ##1 !o_cyc_read)
		|-> (!o_cyc_read && !o_unit_done) [*2])
		else $error("no idle bus cycle after release");
	chk_unit_chan: assert property (o_cyc_read |=> $stable(o_cyc_chan))
		else $error("channel changed inside a unit");
	chk_burst_chan: assert property ((o_unit_done ##1 o_cyc_read)
		|-> $stable(o_cyc_chan))
		else $error("channel changed inside a burst");
	chk_read_grant: assert property ($rose(o_cyc_read) |-> $past(i_bus_gnt))
		else $error("read cycle without bus grant");
	chk_transfer_end_n_cycle: assert property ((o_transfer_end_n != 4'hf)
		|-> (o_cyc_read || o_unit_done))
		else $error("transfer end low outside a cycle");
	chk_slave_okay: assert property (o_hreadyout && !o_hresp)
		else $error("register slave not ready or not okay");
endmodule
bind dma_channel_arbiter dma_arb_checker u_chk (
	.i_clk           (i_clk),
	.i_rst_b         (i_rst_b),
	.i_bus_gnt       (i_bus_gnt),
	.o_hreadyout     (o_hreadyout),
	.o_hresp         (o_hresp),
	.o_cyc_read      (o_cyc_read),
	.o_cyc_write     (o_cyc_write),
	.o_cyc_chan      (o_cyc_chan),
	.o_unit_done     (o_unit_done),
	.o_transfer_end_n(o_transfer_end_n)
);
`default_nettype wire

//--- bench/sys_bus_model.sv
// System bus arbiter model standing for the other bus masters.
// Assumes the other master always wins when it asks.
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// Requests.
	input  wire logic i_bus_req,
	input  wire logic i_other_req,
	// Grant.
	output logic      o_bus_gnt
);
	logic gnt_q;
	logic gnt_d;

	// ==========================================================
	// Grant one cycle after request; a waiting other master
	// takes the bus first, so the DMA side may starve.
	always_comb begin
		gnt_d = i_bus_req && !i_other_req;
	end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			gnt_q <= 1'b0;
		end else begin
			gnt_q <= gnt_d;
		end
	end
	assign o_bus_gnt = gnt_q;
endmodule
`default_nettype wire

//--- bench/test_dma_channel_arbiter.sv
// Testbench for the DMA channel arbiter.
// Assumes the zero-wait register slave and the bus model.
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_arbiter;
	localparam logic [31:0] M_ACT = 32'h0000_0001;
	localparam logic [31:0] M_EXT = 32'h0000_0002;
	localparam logic [31:0] M_EDG = 32'h0000_0004;
	localparam logic [31:0] M_BUR = 32'h0000_0008;
	localparam logic [31:0] M_BLK = 32'h0000_0010;
	localparam logic [31:0] M_SNG = 32'h0000_0020;
	localparam logic [31:0] M_TEN = 32'h0000_0040;
	localparam logic [31:0] M_WSZ = 32'h0000_0100;
	localparam logic [31:0] M_USB = 32'h0000_0400;
	localparam logic [31:0] M_ABT = 32'h0000_0800;
	logic clk = 0, rst_b = 0, hwrite = 0, nmi = 0, other = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
	logic [1:0] htrans = 0, sz, ch, first_ch;
	logic [3:0] ext_n = 4'hf, last = 4'hf, transfer_end_n_n, transfer_end_n_seen;
	logic hready, hresp, gnt, breq, rd, wr, sng, usb, done, got, sng_seen;
	logic usb_seen;
	logic [1:0] sz_seen;
	int error_cnt = 0, checks_done = 0, units[4], u, dn;

	// ==========================================================
	// Design, bus model and clock.
	dma_channel_arbiter u_dut (.i_clk(clk), .i_rst_b(rst_b),
		.i_hsel(1'b1), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
		.o_hresp(hresp), .i_external_request_n(ext_n), .i_nmi(nmi),
		.i_last_unit(last), .i_other_master_req(other),
		.i_bus_gnt(gnt), .o_bus_req(breq), .o_cyc_read(rd),
		.o_cyc_write(wr), .o_cyc_single(sng), .o_cyc_usb(usb),
		.o_cyc_size(sz), .o_cyc_chan(ch), .o_unit_done(done),
		.o_transfer_end_n(transfer_end_n_n));
	sys_bus_model u_bus (.i_clk(clk), .i_rst_b(rst_b),
		.i_bus_req(breq), .i_other_req(other), .o_bus_gnt(gnt));
	always #5 clk = ~clk;

	// Log every unit by channel, with the first winner of a run.
	always @(posedge clk) begin
		if (rd === 1'b1) begin
			units[ch]++;
			sng_seen |= sng;
			usb_seen |= usb;
			sz_seen |= sz;
			if (!got) begin
				first_ch = ch;
				got = 1;
			end
		end
		if (done === 1'b1) begin
			dn++;
		end
		transfer_end_n_seen |= ~transfer_end_n_n;
	end

	// ==========================================================
	// Bus tasks; read data is taken at the edge that ends the data phase.
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] wd);
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		d = hrdata;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic clr();
		units = '{0, 0, 0, 0};
		got = 0;
		transfer_end_n_seen = 0;
		sng_seen = 0;
		usb_seen = 0;
		sz_seen = 0;
		dn = 0;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] md(input int i);
		return dma_arb_pkg::OFF_MODE0 + 8'(4 * i);
	endfunction

	// ==========================================================
	// Test sequence.
	initial begin
		clr();
		repeat (5) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		xfer(md(0), 0, 0); cmp(d, 0);
		xfer(dma_arb_pkg::OFF_BEATS0, 0, 0); cmp(d, 1);
		xfer(8'h40, 1, 32'h0000_00ff);
		xfer(8'h40, 0, 0); cmp(d, 0);
		// Two channels wait while another master owns the bus.
		xfer(md(3), 1, M_ACT);
		xfer(md(1), 1, M_ACT | M_TEN);
		clr();
		repeat (20) @(posedge clk);
		cmp(units[1] + units[3], 0);
		cmp(breq, 1);
		other <= 0;
		repeat (40) @(posedge clk);
		cmp(first_ch, 1);
		cmp(units[1], 1); cmp(units[3], 1);
		cmp(transfer_end_n_seen, 4'h2);
		xfer(md(1), 0, 0); cmp(d, M_TEN);
		// Burst holds off a higher channel until the abort.
		last <= 0;
		xfer(md(1), 1, M_ACT | M_BUR);
		repeat (6) @(posedge clk);
		xfer(md(0), 1, M_ACT);
		clr();
		repeat (20) @(posedge clk);
		cmp(units[0], 0); cmp(units[1] > 4, 1);
		nmi <= 1;
		repeat (10) @(posedge clk);
		xfer(md(1), 0, 0); cmp(d, M_ABT | M_BUR);
		cmp(units[0] > 0, 1);
		nmi <= 0;
		last <= 4'hf;
		repeat (20) @(posedge clk);
		xfer(md(0), 0, 0); cmp(d, 0);
		// Edge sensing takes one unit per falling edge.
		last <= 0;
		xfer(md(2), 1, M_ACT | M_EXT | M_EDG | M_USB | M_WSZ);
		clr();
		ext_n[2] <= 0;
		repeat (40) @(posedge clk);
		cmp(units[2], 1);
		ext_n[2] <= 1;
		repeat (5) @(posedge clk);
		ext_n[2] <= 0;
		repeat (30) @(posedge clk);
		cmp(units[2], 2);
		cmp(usb_seen, 1);
		cmp(sz_seen, 2'b01);
		ext_n[2] <= 1;
		xfer(md(2), 1, 0);
		// Level sensing in single address mode repeats while low.
		xfer(md(3), 1, M_ACT | M_EXT | M_SNG);
		clr();
		ext_n[3] <= 0;
		repeat (40) @(posedge clk);
		cmp(units[3] > 1, 1); cmp(sng_seen, 1);
		ext_n[3] <= 1;
		repeat (10) @(posedge clk);
		u = units[3];
		repeat (20) @(posedge clk);
		cmp(units[3], u);
		xfer(md(3), 1, 0);
		// One short request moves one whole block of three.
		xfer(dma_arb_pkg::OFF_BEATS0, 1, 3);
		xfer(md(0), 1, M_ACT | M_EXT | M_BLK);
		clr();
		ext_n[0] <= 0;
		repeat (3) @(posedge clk);
		ext_n[0] <= 1;
		repeat (40) @(posedge clk);
		cmp(units[0], 3);
		cmp(dn, 3);
		results();
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#200000;
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire

//--- include/dma_arb_pkg.sv
// Package for the four-channel DMA arbiter and request sampler.
// Assumes a single 100 MHz clock and an AHB-Lite register slave.
package dma_arb_pkg;

	// ==========================================================
	// Geometry.
	localparam int unsigned N_CH   = 4;
	localparam int unsigned BEAT_W = 8;

	// ==========================================================
	// Register byte offsets, one word per channel mode register,
	// then a status word and one beat-count word per channel.
	localparam logic [7:0] OFF_MODE0  = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_BEATS0 = 8'h20;

	// ==========================================================
	// Fields of the channel mode register.
	localparam int unsigned F_ACTIVE  = 0;
	localparam int unsigned F_EXTREQ  = 1;
	localparam int unsigned F_EDGE    = 2;
	localparam int unsigned F_BURST   = 3;
	localparam int unsigned F_BLOCK   = 4;
	localparam int unsigned F_SINGLE  = 5;
	localparam int unsigned F_TENDEN  = 6;
	localparam int unsigned F_DIRWR   = 7;
	localparam int unsigned F_SIZE    = 8;
	localparam int unsigned F_USB     = 10;
	localparam int unsigned F_ABORTED = 11;
	localparam logic [11:0] MODE_RST  = 12'h000;
	localparam logic [11:0] MODE_WMASK = 12'h7ff;

	// ==========================================================
	// Timing: the minimum idle gap between channel transfers.
	localparam int unsigned CLK_MHZ    = 100;
	localparam int unsigned GAP_NS     = 10;
	localparam int unsigned GAP_CYC    = (GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RD_CYC     = 1;
	localparam int unsigned WR_CYC     = 1;

	// ==========================================================
	// Sequencer states.
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_READ  = 5'b00010,
		ST_WRITE = 5'b00100,
		ST_REL   = 5'b01000,
		ST_GAP   = 5'b10000
	} seq_e;

	// Sampler phases: waiting for low, or waiting for high after edge use.
	typedef enum logic [1:0] {
		SP_LOW  = 2'b01,
		SP_HIGH = 2'b10
	} samp_e;

endpackage

//--- src/dma_channel_arbiter.sv
// Four-channel DMA arbiter and bus-cycle sequencer with AHB-Lite
// registers. Assumes one clock; the system bus arbiter outside grants
// the bus when o_bus_req is high and i_bus_gnt returns.
//
// Operation
// - Fixed priority, channel 0 highest, channel 3 lowest, on simultaneous requests.
// - Outside auto cycle steal, pick highest other requester; start after release.
// - At each release, other master first; otherwise two idle cycles minimum.
// - Never switch channel mid-burst or mid-block.
// - Auto cycle steal: higher priority wins next release; lower waits.
// - Normal cycle steal releases bus after each unit for a CPU cycle.
// - Burst runs units back to back; all other requests wait.
// - NMI clears active bit of burst channels; burst aborts after current unit, or after the next one if the NMI edge lands in a write cycle.
// - A last burst cycle already launched still completes fully.
// - Block cycle steal moves one whole block per request, then releases.
// - Dual address cycle steal allows USB FIFO as source or destination.
// - Request pin sampled every clock from the edge after enabling write.
// - Edge mode latches low, clears at activation, then waits for high.
// - Edge mode resumes acceptance after write cycle once high was seen.
// - Level mode clears at activation, resumes at write cycle end.
// - Single address reads memory to device or device to memory, any size.
// - Single address releases the bus after each unit per request.
// - CPU sets active bit; controller clears it on end or NMI abort.
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_arbiter (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// AHB-Lite slave.
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	// External request pins and NMI.
	input  wire logic [3:0]  i_external_request_n,
	input  wire logic        i_nmi,
	// Per-channel completion from the address/count block.
	input  wire logic [3:0]  i_last_unit,
	// System bus arbitration.
	input  wire logic        i_other_master_req,
	input  wire logic        i_bus_gnt,
	output logic             o_bus_req,
	// Transfer cycle strobes.
	output logic             o_cyc_read,
	output logic             o_cyc_write,
	output logic             o_cyc_single,
	output logic             o_cyc_usb,
	output logic      [1:0]  o_cyc_size,
	output logic      [1:0]  o_cyc_chan,
	output logic             o_unit_done,
	output logic      [3:0]  o_transfer_end_n
);

	localparam logic [7:0] BEATS_RST = 8'h01;

	logic [11:0]             mode_q [4];
	logic [11:0]             mode_d [4];
	logic [7:0]              beats_q [4];
	logic [3:0]              pend;
	logic [3:0]              act_pulse;
	logic [3:0]              wend_pulse;
	logic [3:0]              req;
	dma_arb_pkg::seq_e       st_q, st_d;
	logic [1:0]              ch_q, ch_d;
	logic [7:0]              cnt_q, cnt_d;
	logic                    last_q, last_d;
	logic                    abort_q, abort_d;
	logic                    ap_q;
	logic                    apw_q;
	logic [7:0]              ap_addr_q;
	logic                    transfer_end_n_q [4];
	logic                    transfer_end_n_d [4];
	logic [1:0]              win;
	logic                    any;
	logic [3:0]              nmi_clr;
	logic                    nmi_s1, nmi_s2, nmi_s3;
	logic [3:0]              done_clr;

	// ==========================================================
	// Per-channel request samplers and raw requests.
	for (genvar g = 0; g < 4; g++) begin : g_ch
		dma_req_sampler u_samp (
			.i_clk       (i_clk),
			.i_rst_b     (i_rst_b),
			.i_enable    (mode_q[g][dma_arb_pkg::F_ACTIVE]
				&& mode_q[g][dma_arb_pkg::F_EXTREQ]),
			.i_edge      (mode_q[g][dma_arb_pkg::F_EDGE]),
			.i_ext_req_n (i_external_request_n[g]),
			.i_activate  (act_pulse[g]),
			.i_write_end (wend_pulse[g]),
			.o_pending   (pend[g])
		);
		assign req[g] = mode_q[g][dma_arb_pkg::F_ACTIVE]
			&& (mode_q[g][dma_arb_pkg::F_EXTREQ] ? pend[g] : 1'b1);
		assign act_pulse[g] = (st_q == dma_arb_pkg::ST_IDLE)
			&& (st_d == dma_arb_pkg::ST_READ) && (ch_d == 2'(g));
		assign wend_pulse[g] = (st_q == dma_arb_pkg::ST_WRITE)
			&& (st_d != dma_arb_pkg::ST_WRITE) && (ch_q == 2'(g));
		assign nmi_clr[g] = nmi_s2 && !nmi_s3
			&& mode_q[g][dma_arb_pkg::F_BURST];
		assign o_transfer_end_n[g] = !transfer_end_n_q[g];
	end

	// ==========================================================
	// NMI pin is asynchronous; detect its rising edge after sync.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			nmi_s1 <= 1'b0;
			nmi_s2 <= 1'b0;
			nmi_s3 <= 1'b0;
		end else begin
			nmi_s1 <= i_nmi;
			nmi_s2 <= nmi_s1;
			nmi_s3 <= nmi_s2;
		end
	end

	// ==========================================================
	// Fixed priority pick. In auto cycle steal the active channel
	// competes normally, so only higher channels beat it; elsewhere
	// the just-served channel is skipped if another waits.
	always_comb begin
		logic [3:0] cand;
		cand = req;
		if (!(mode_q[ch_q][dma_arb_pkg::F_EXTREQ] == 1'b0
			&& !mode_q[ch_q][dma_arb_pkg::F_BURST])
			&& (req & ~(4'b0001 << ch_q)) != 4'h0) begin
			cand = req & ~(4'b0001 << ch_q);
		end
		any = cand != 4'h0;
		win = 2'd0;
		for (int i = 3; i >= 0; i--) begin
			if (cand[i]) begin
				win = 2'(i);
			end
		end
	end

	// ==========================================================
	// Sequencer: read cycle, write cycle, then either continue
	// (burst or inside a block) or release for two cycles minimum.
	always_comb begin
		st_d    = st_q;
		ch_d    = ch_q;
		cnt_d   = cnt_q;
		last_d  = last_q;
		abort_d = abort_q || (nmi_clr[ch_q] && st_q != dma_arb_pkg::ST_IDLE);
		for (int i = 0; i < 4; i++) begin
			transfer_end_n_d[i] = 1'b0;
		end
		done_clr = 4'h0;
		unique case (st_q)
			dma_arb_pkg::ST_IDLE: begin
				abort_d = 1'b0;
				if (any && i_bus_gnt) begin
					st_d  = dma_arb_pkg::ST_READ;
					ch_d  = win;
					cnt_d = beats_q[win];
				end
			end
			dma_arb_pkg::ST_READ: begin
				// Single address uses one memory cycle only; the
				// device strobes data during it.
				last_d = i_last_unit[ch_q];
				transfer_end_n_d[ch_q] = i_last_unit[ch_q]
					&& mode_q[ch_q][dma_arb_pkg::F_TENDEN];
				st_d = dma_arb_pkg::ST_WRITE;
			end
			dma_arb_pkg::ST_WRITE: begin
				cnt_d = cnt_q - 8'd1;
				if (last_q) begin
					done_clr[ch_q] = 1'b1;
					st_d = dma_arb_pkg::ST_REL;
				end else if (abort_q) begin
					st_d = dma_arb_pkg::ST_REL;
				end else if (mode_q[ch_q][dma_arb_pkg::F_BURST]) begin
					st_d = dma_arb_pkg::ST_READ;
				end else if (mode_q[ch_q][dma_arb_pkg::F_BLOCK]
					&& cnt_q > 8'd1) begin
					st_d = dma_arb_pkg::ST_READ;
				end else begin
					st_d = dma_arb_pkg::ST_REL;
				end
			end
			dma_arb_pkg::ST_REL: begin
				st_d = dma_arb_pkg::ST_GAP;
			end
			dma_arb_pkg::ST_GAP: begin
				// Another master takes the bus here if it asks; the
				// outside arbiter holds grant low until it is done.
				st_d = dma_arb_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q    <= dma_arb_pkg::ST_IDLE;
			ch_q    <= 2'd0;
			cnt_q   <= 8'h00;
			last_q  <= 1'b0;
			abort_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				transfer_end_n_q[i] <= 1'b0;
			end
		end else begin
			st_q    <= st_d;
			ch_q    <= ch_d;
			cnt_q   <= cnt_d;
			last_q  <= last_d;
			abort_q <= abort_d;
			for (int i = 0; i < 4; i++) begin
				transfer_end_n_q[i] <= transfer_end_n_d[i] || (transfer_end_n_q[i]
					&& st_q == dma_arb_pkg::ST_READ);
			end
		end
	end

	// ==========================================================
	// Bus request: asked while idle with work, dropped at release
	// so that a waiting master wins the gap.
	assign o_bus_req = (st_q == dma_arb_pkg::ST_IDLE && any)
		|| st_q == dma_arb_pkg::ST_READ || st_q == dma_arb_pkg::ST_WRITE;

	always_comb begin
		o_cyc_read   = st_q == dma_arb_pkg::ST_READ;
		o_cyc_write  = st_q == dma_arb_pkg::ST_WRITE
			&& !mode_q[ch_q][dma_arb_pkg::F_SINGLE];
		o_cyc_single = mode_q[ch_q][dma_arb_pkg::F_SINGLE]
			&& st_q == dma_arb_pkg::ST_READ;
		o_cyc_usb    = mode_q[ch_q][dma_arb_pkg::F_USB];
		o_cyc_size   = mode_q[ch_q][dma_arb_pkg::F_SIZE +: 2];
		o_cyc_chan   = ch_q;
		o_unit_done  = st_q == dma_arb_pkg::ST_WRITE;
	end

	// ==========================================================
	// AHB-Lite slave: zero wait states, always OKAY.
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ap_q      <= 1'b0;
			apw_q     <= 1'b0;
			ap_addr_q <= 8'h00;
		end else if (i_hready) begin
			ap_q      <= i_hsel && i_htrans[1];
			apw_q     <= i_hwrite;
			ap_addr_q <= i_haddr[7:0];
		end
	end

	// Mode registers: hardware clears of the active bit win over a
	// simultaneous software write, since the channel has stopped.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			mode_d[i] = mode_q[i];
			if (ap_q && apw_q
				&& ap_addr_q == dma_arb_pkg::OFF_MODE0 + 8'(4 * i)) begin
				mode_d[i] = i_hwdata[11:0] & dma_arb_pkg::MODE_WMASK;
			end
			if (done_clr[i] || nmi_clr[i]) begin
				mode_d[i][dma_arb_pkg::F_ACTIVE] = 1'b0;
			end
			if (nmi_clr[i]) begin
				mode_d[i][dma_arb_pkg::F_ABORTED] = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < 4; i++) begin
				mode_q[i]  <= dma_arb_pkg::MODE_RST;
				beats_q[i] <= BEATS_RST;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				mode_q[i] <= mode_d[i];
				if (ap_q && apw_q && ap_addr_q
					== dma_arb_pkg::OFF_BEATS0 + 8'(4 * i)) begin
					beats_q[i] <= i_hwdata[7:0];
				end
			end
		end
	end

	// Read mux: combinational in the data phase.
	always_comb begin
		o_hrdata = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (ap_addr_q == dma_arb_pkg::OFF_MODE0 + 8'(4 * i)) begin
				o_hrdata = {20'h0_0000, mode_q[i]};
			end
			if (ap_addr_q == dma_arb_pkg::OFF_BEATS0 + 8'(4 * i)) begin
				o_hrdata = {24'h00_0000, beats_q[i]};
			end
		end
		if (ap_addr_q == dma_arb_pkg::OFF_STATUS) begin
			o_hrdata = {22'h00_0000, pend, 1'b0, st_q};
		end
		if (!ap_q || apw_q) begin
			o_hrdata = 32'h0000_0000;
		end
	end

endmodule
`default_nettype wire

//--- src/dma_req_sampler.sv
// One channel's external request sampler: synchroniser, edge or level
// sensing, pending latch. Assumes the sequencer pulses activate and
// write-end on separate clocks, never together.
`timescale 1ns/1ps
`default_nettype none
module dma_req_sampler (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	// Configuration.
	input  wire logic i_enable,
	input  wire logic i_edge,
	// Pin from outside the clock domain.
	input  wire logic i_ext_req_n,
	// Sequencer events.
	input  wire logic i_activate,
	input  wire logic i_write_end,
	// Result.
	output logic      o_pending
);

	logic               sync1_q, sync2_q;
	logic               pend_q, pend_d;
	logic               accept_q, accept_d;
	dma_arb_pkg::samp_e ph_q, ph_d;

	// ==========================================================
	// Two-flop synchroniser; only the second flop feeds logic.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= i_ext_req_n;
			sync2_q <= sync1_q;
		end
	end

	// ==========================================================
	// Sampling starts the edge after enable is seen, since enable
	// itself is registered by the write cycle that sets it.
	always_comb begin
		pend_d   = pend_q;
		accept_d = accept_q;
		ph_d     = ph_q;
		if (!i_enable) begin
			pend_d   = 1'b0;
			accept_d = 1'b1;
			ph_d     = dma_arb_pkg::SP_LOW;
		end else begin
			if (ph_q == dma_arb_pkg::SP_HIGH && sync2_q) begin
				ph_d = dma_arb_pkg::SP_LOW;
			end
			if (i_write_end) begin
				// Acceptance reopens after every write cycle. In edge
				// mode the high-phase gate still blocks a new request
				// until the pin has been high, however late that is,
				// so a slow pin cannot lock the channel out for good.
				accept_d = 1'b1;
			end
			if (accept_q && !sync2_q && ph_q == dma_arb_pkg::SP_LOW) begin
				pend_d = 1'b1;
			end
			if (i_activate) begin
				pend_d   = 1'b0;
				accept_d = 1'b0;
				if (i_edge) begin
					ph_d = dma_arb_pkg::SP_HIGH;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_q   <= 1'b0;
			accept_q <= 1'b1;
			ph_q     <= dma_arb_pkg::SP_LOW;
		end else begin
			pend_q   <= pend_d;
			accept_q <= accept_d;
			ph_q     <= ph_d;
		end
	end

	assign o_pending = pend_q;

endmodule
`default_nettype wire
